// [hdl/amp_protection_fault_control.sv]
// Purpose: protection and fault control of a four half-bridge power stage
// Assumes: pin inputs asynchronous, rst is the power-on reset
// Notes:
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "amp_prot_regs.svh"
module amp_protection_fault_control
	import amp_prot_pkg::*;
#(
	parameter int FRAME_CYC  = 25,
	parameter int CHK_CYC    = 64,
	parameter int RAMP_CYC   = 32,
	parameter int EXT_TO_CYC = 40,
	parameter int OVL_MAX    = 16
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reset_pin_n,
	input  wire logic        heat_warning,
	input  wire logic        heat_shutdown,
	input  wire logic        supply_low_guard,
	input  wire logic        por_low,
	input  wire logic [3:0]  boot_cap_low,
	input  wire logic [3:0]  over_current,
	input  wire logic [3:0]  clip_saturated,
	input  wire logic [1:0]  dc_imbalance,
	input  wire logic [3:0]  short_to_gnd,
	input  wire logic [3:0]  short_to_supply,
	input  wire logic        ext_switch_clock,
	output logic             fault_n_out,
	output logic             fault_n_oe,
	output logic             clip_heat_warn_n_out,
	output logic             clip_heat_warn_n_oe,
	output logic [3:0]       hb_hiz,
	output logic [3:0]       hb_high_off,
	output logic [3:0]       hb_flip,
	output logic [3:0]       inject_pulse,
	output logic [3:0]       pulldown_en,
	output logic             ramp_down,
	output logic             chk_gnd_test,
	output logic             chk_sup_test
);
	localparam int FW = $clog2(FRAME_CYC);
	localparam int KW = $clog2(CHK_CYC + 1);
	localparam int RW = $clog2(RAMP_CYC + 1);
	localparam int EW = $clog2(EXT_TO_CYC + 1);
	localparam int PW = $clog2(`CLIP_PULSE_CYC + 1);

	initial begin
		if (FRAME_CYC < 4 || CHK_CYC < 1 || RAMP_CYC < 1 || EXT_TO_CYC < 2)
			$error("timing parameters out of range");
	end

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	localparam int SN = 28;
	// reset pin bit rests released and power-on bit rests asserted: no false reset
	// edge after reset, and the check waits for a real supply reading
	localparam logic [SN-1:0] SYNC_IDLE = {1'b1, 3'h0, 1'b1, 23'h00_0000};
	logic [SN-1:0] pin_raw;
	logic [SN-1:0] s1_ff;
	logic [SN-1:0] s2_ff;
	assign pin_raw = {reset_pin_n, heat_warning, heat_shutdown, supply_low_guard, por_low,
		boot_cap_low, over_current, clip_saturated, dc_imbalance, short_to_gnd,
		short_to_supply, ext_switch_clock};

	// two stages; only the second is read
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_ff <= SYNC_IDLE;
			s2_ff <= SYNC_IDLE;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
		end
	end

	logic       rpin;
	logic       hwarn;
	logic       hshut;
	logic       slow;
	logic       por_s;
	logic [3:0] bootl;
	logic [3:0] oc_s;
	logic [3:0] sat_s;
	logic [1:0] dci_s;
	logic [3:0] sg_s;
	logic [3:0] ss_s;
	logic       eclk_s;
	assign {rpin, hwarn, hshut, slow, por_s, bootl, oc_s, sat_s, dci_s, sg_s, ss_s,
		eclk_s} = s2_ff;

	// ****************************************************************
	// apb registers
	// ****************************************************************
	logic [2:0] ctrl_ff;
	out_mode_e  mode;
	logic       slave_mode;
	logic [31:0] status;
	assign mode       = out_mode_e'(ctrl_ff[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
	assign slave_mode = ctrl_ff[`CTRL_SLAVE_BIT];
	assign pready     = 1'b1;

	// control word write
	always_ff @(posedge clk) begin
		if (rst)
			ctrl_ff <= `CTRL_RST;
		else if (psel && penable && pwrite && paddr == `CTRL_OFF)
			ctrl_ff <= pwdata[2:0];
	end

	// read data and error; unmapped reads as zero with error
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !(paddr == `CTRL_OFF || paddr == `STAT_OFF);
			if (paddr == `CTRL_OFF)
				prdata <= {29'h0000_0000, ctrl_ff};
			else if (paddr == `STAT_OFF)
				prdata <= status;
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// frame divider
	// ****************************************************************
	logic [FW-1:0] fdiv_ff;
	logic [1:0]    fnum_ff;
	logic          frame_tick;
	assign frame_tick = (fdiv_ff == FW'(FRAME_CYC - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			fdiv_ff <= '0;
			fnum_ff <= 2'h0;
		end else begin
			fdiv_ff <= frame_tick ? '0 : fdiv_ff + 1'b1;
			if (frame_tick)
				fnum_ff <= fnum_ff + 2'h1;
		end
	end

	// ****************************************************************
	// startup pin short check
	// ****************************************************************
	chk_state_e     chk_ff;
	chk_state_e     chk_ret_ff;
	logic [KW-1:0]  ctim_ff;
	logic           chk_busy;
	logic           chk_done;
	assign chk_busy = (chk_ff != CHK_DONE);
	assign chk_done = (ctim_ff == KW'(CHK_CYC));

	always_ff @(posedge clk) begin
		if (rst) begin
			chk_ff     <= CHK_WAIT;
			chk_ret_ff <= CHK_GND;
			ctim_ff    <= '0;
		end else begin
			case (chk_ff)
				CHK_WAIT: begin
					if (!por_s)
						chk_ff <= (mode == MODE_SINGLE) ? CHK_DONE : CHK_GND;
					ctim_ff <= '0;
				end
				CHK_GND: begin
					ctim_ff <= ctim_ff + 1'b1;
					if (sg_s != 4'h0) begin
						chk_ret_ff <= CHK_GND;
						chk_ff     <= CHK_HOLD;
					end else if (chk_done) begin
						chk_ff  <= CHK_SUP;
						ctim_ff <= '0;
					end
				end
				CHK_SUP: begin
					ctim_ff <= ctim_ff + 1'b1;
					if (ss_s != 4'h0) begin
						chk_ret_ff <= CHK_SUP;
						chk_ff     <= CHK_HOLD;
					end else if (chk_done) begin
						chk_ff <= CHK_DONE;
					end
				end
				CHK_HOLD: begin
					ctim_ff <= '0;
					if (sg_s == 4'h0 && ss_s == 4'h0)
						chk_ff <= chk_ret_ff;
				end
				CHK_DONE: chk_ff <= CHK_DONE;
				default:  chk_ff <= CHK_WAIT;
			endcase
		end
	end

	// ****************************************************************
	// reset pin handling
	// ****************************************************************
	// reset pin ignored while checking
	logic          rpin_eff;
	logic          rpin_d_ff;
	logic          rpin_rise;
	logic [RW-1:0] ramp_ff;
	assign rpin_eff  = chk_busy ? 1'b1 : rpin;
	assign rpin_rise = rpin_eff && !rpin_d_ff;

	always_ff @(posedge clk) begin
		if (rst)
			rpin_d_ff <= 1'b1;
		else
			rpin_d_ff <= rpin_eff;
	end

	always_ff @(posedge clk) begin
		if (rst || rpin_eff)
			ramp_ff <= '0;
		else if (ramp_ff != RW'(RAMP_CYC))
			ramp_ff <= ramp_ff + 1'b1;
	end
	assign ramp_down = !rpin_eff && (ramp_ff != RW'(RAMP_CYC));

	// ****************************************************************
	// global faults
	// ****************************************************************
	logic heat_latch_ff;
	logic ext_lost;

	always_ff @(posedge clk) begin
		if (rst || !rpin_eff)
			heat_latch_ff <= 1'b0;
		else if (hshut)
			heat_latch_ff <= 1'b1;
	end

	logic          eclk_d_ff;
	logic [EW-1:0] eto_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			eclk_d_ff <= 1'b0;
			eto_ff    <= '0;
		end else begin
			eclk_d_ff <= eclk_s;
			if (!slave_mode || (eclk_s && !eclk_d_ff))
				eto_ff <= '0;
			else if (eto_ff != EW'(EXT_TO_CYC))
				eto_ff <= eto_ff + 1'b1;
		end
	end
	assign ext_lost = slave_mode && (eto_ff == EW'(EXT_TO_CYC));

	// ****************************************************************
	// half-bridge guards
	// ****************************************************************
	hb_guard_if gi [4] ();
	logic [3:0] trip;
	logic [3:0] lim;
	logic [3:0] flip_w;
	logic       dc_on;
	// dc protection only in bridged and mixed modes, not parallel bridged
	assign dc_on = (mode == MODE_BRIDGED) || (mode == MODE_MIXED);

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_hb
			assign gi[i].frame_tick = frame_tick;
			assign gi[i].oc_event   = oc_s[i];
			assign gi[i].dc_force   = dc_on && dci_s[i/2] && !(mode == MODE_MIXED && i >= 2);
			// power-on reset and reset rise clear
			assign gi[i].clr        = por_s || rpin_rise;
			assign trip[i]          = gi[i].trip;
			assign lim[i]           = gi[i].limiting;
			assign flip_w[i]        = gi[i].flip;
			hb_guard #(.OVL_MAX(OVL_MAX)) u_guard (
				.clk (clk),
				.rst (rst),
				.g   (gi[i])
			);
		end
	endgenerate

	// spread a trip over its channel
	logic [3:0] chan_off;
	always_comb begin
		case (mode)
			MODE_PAR_BRG: chan_off = {4{|trip}};
			MODE_SINGLE:  chan_off = trip;
			MODE_MIXED:   chan_off = {trip[3:2], {2{|trip[1:0]}}};
			default:      chan_off = {{2{|trip[3:2]}}, {2{|trip[1:0]}}};
		endcase
	end

	// ****************************************************************
	// bridge outputs
	// ****************************************************************
	logic global_off;
	assign global_off = heat_latch_ff || slow || por_s || ext_lost || chk_busy
		|| (!rpin_eff && !ramp_down);

	always_ff @(posedge clk) begin
		if (rst) begin
			hb_hiz       <= 4'hf;
			hb_high_off  <= 4'h0;
			hb_flip      <= 4'h0;
			inject_pulse <= 4'h0;
			pulldown_en  <= 4'h0;
		end else begin
			hb_hiz      <= {4{global_off}} | chan_off;
			hb_high_off <= bootl;
			hb_flip     <= flip_w & ~chan_off;
			inject_pulse <= (sat_s | lim) & {4{frame_tick && fnum_ff == 2'(`INJECT_EVERY - 1)}}
				& ~chan_off & {4{!global_off}};
			pulldown_en <= {4{!rpin_eff}};
		end
	end

	// ****************************************************************
	// reporting pins
	// ****************************************************************
	logic [PW-1:0] cpul_ff;
	// clip pulse at each saturated frame
	always_ff @(posedge clk) begin
		if (rst)
			cpul_ff <= '0;
		else if (frame_tick && (|sat_s))
			cpul_ff <= PW'(`CLIP_PULSE_CYC);
		else if (cpul_ff != '0)
			cpul_ff <= cpul_ff - 1'b1;
	end

	logic fault_low;
	// any reported fault; reset low releases
	assign fault_low = chk_busy || (rpin_eff && (heat_latch_ff || (|trip) || slow || por_s));

	// open drain, driven only when low
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_n_oe          <= 1'b0;
			clip_heat_warn_n_oe <= 1'b0;
		end else begin
			fault_n_oe          <= fault_low;
			clip_heat_warn_n_oe <= hwarn || (cpul_ff != '0);
		end
	end
	assign fault_n_out          = 1'b0;
	assign clip_heat_warn_n_out = 1'b0;
	assign chk_gnd_test         = (chk_ff == CHK_GND);
	assign chk_sup_test         = (chk_ff == CHK_SUP);

	// status word
	assign status = {15'h0000, chk_ff, lim, trip, ext_lost, por_s, slow, heat_latch_ff,
		hwarn, fault_low};
endmodule : amp_protection_fault_control
`default_nettype wire

// [hdl/amp_prot_regs.svh]
// Purpose: register map, reset values and timing counts of the protection block
// Assumes: 10 MHz clock, APB with one 32-bit word per register
// Notes:   definitions only
`ifndef AMP_PROT_REGS_SVH
`define AMP_PROT_REGS_SVH

// ****************************************************************
// register offsets and fields
// ****************************************************************
`define CTRL_OFF        12'h000
`define STAT_OFF        12'h004
`define CTRL_RST        3'h0
`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1
`define CTRL_SLAVE_BIT  2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS   100
`define CLIP_PULSE_NS   500
`define CLIP_PULSE_CYC  ((`CLIP_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INJECT_EVERY    4
`define FLIP_EVERY      3

`endif

// [hdl/amp_prot_pkg.sv]
// Purpose: shared types of the protection block
// Assumes: nothing
// Notes:   numbers live in amp_prot_regs.svh
package amp_prot_pkg;
	// output configuration
	typedef enum logic [1:0] {
		MODE_BRIDGED  = 2'b00,
		MODE_PAR_BRG  = 2'b01,
		MODE_SINGLE   = 2'b10,
		MODE_MIXED    = 2'b11
	} out_mode_e;

	// startup pin short check
	typedef enum logic [2:0] {
		CHK_WAIT = 3'b000,
		CHK_GND  = 3'b001,
		CHK_SUP  = 3'b010,
		CHK_HOLD = 3'b011,
		CHK_DONE = 3'b100
	} chk_state_e;
endpackage : amp_prot_pkg

// [hdl/hb_guard_if.sv]
// Purpose: carrier between the top and one half-bridge guard
// Assumes: single clock domain
// Notes:   one instance per half bridge
`timescale 1ns/1ps
`default_nettype none
interface hb_guard_if;
	logic frame_tick;  // start of a switching frame
	logic oc_event;    // overcurrent seen this cycle
	logic dc_force;    // dc imbalance steps counter up each cycle to max
	logic clr;         // clear overload latch
	logic flip;        // half-bridge state flip
	logic limiting;    // cycle limiting active
	logic trip;        // overload latched
	modport top   (output frame_tick, oc_event, dc_force, clr, input flip, limiting, trip);
	modport guard (input frame_tick, oc_event, dc_force, clr, output flip, limiting, trip);
endinterface : hb_guard_if
`default_nettype wire

// [hdl/hb_guard.sv]
// Purpose: per half-bridge overload counter and cycle current limiting
// Assumes: frame_tick is a one-cycle enable
// Notes:   trip stays latched until clr
`timescale 1ns/1ps
`default_nettype none
module hb_guard #(
	parameter int OVL_MAX = 16
) (
	input  wire logic  clk,
	input  wire logic  rst,
	hb_guard_if.guard  g
);
	localparam int CW = $clog2(OVL_MAX + 1);
	localparam logic [CW-1:0] CMAX = CW'(OVL_MAX);

	initial begin
		if (OVL_MAX < 2) $error("OVL_MAX must be at least 2");
	end

	logic [CW-1:0] cnt_ff;
	logic          oc_seen_ff;
	logic          trip_ff;
	logic          flip_ff;
	logic [1:0]    phase_ff;
	logic          lim_ff;

	// ****************************************************************
	// overload counter
	// ****************************************************************
	// up on overcurrent frame
	always_ff @(posedge clk) begin
		if (rst || g.clr) begin
			cnt_ff     <= '0;
			oc_seen_ff <= 1'b0;
		end else if (g.dc_force) begin
			cnt_ff     <= (cnt_ff == CMAX) ? cnt_ff : cnt_ff + 1'b1;
			oc_seen_ff <= 1'b0;
		end else if (g.frame_tick) begin
			if (oc_seen_ff || g.oc_event)
				cnt_ff <= (cnt_ff == CMAX) ? cnt_ff : cnt_ff + 1'b1;
			else if (cnt_ff != '0)
				cnt_ff <= cnt_ff - 1'b1;
			oc_seen_ff <= 1'b0;
		end else if (g.oc_event) begin
			oc_seen_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || g.clr)
			trip_ff <= 1'b0;
		else if (cnt_ff == CMAX)
			trip_ff <= 1'b1;
	end

	// ****************************************************************
	// cycle by cycle limiting
	// ****************************************************************
	// frame phase so flips happen at a third of the frame rate
	always_ff @(posedge clk) begin
		if (rst)
			phase_ff <= 2'h0;
		else if (g.frame_tick)
			phase_ff <= (phase_ff == 2'(`FLIP_EVERY - 1)) ? 2'h0 : phase_ff + 2'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flip_ff <= 1'b0;
		end else if (g.frame_tick) begin
			flip_ff <= 1'b0;  // flip clears at next frame
		end else if (g.oc_event && phase_ff == 2'h0) begin
			flip_ff <= 1'b1;
		end
	end

	// limiting flag self-clears after a quiet frame, reported in the status word
	always_ff @(posedge clk) begin
		if (rst)
			lim_ff <= 1'b0;
		else if (g.oc_event)
			lim_ff <= 1'b1;
		else if (g.frame_tick && !oc_seen_ff)
			lim_ff <= 1'b0;
	end

	assign g.trip     = trip_ff;
	assign g.flip     = flip_ff;
	assign g.limiting = lim_ff;
endmodule : hb_guard
`default_nettype wire

// [test/prot_mcu_model.sv]
// Purpose: controller model that drives the device reset pin
// Assumes: fault_n is the resolved open-drain level
// Notes:   HOLD_CYC stands in for the 4 ms wait
`timescale 1ns/1ps
`default_nettype none
module prot_mcu_model #(
	parameter int HOLD_CYC = 40000
) (
	input  wire logic clk,
	input  wire logic fault_n,
	input  wire logic req_reset,
	output logic      reset_pin_n
);
	// ********************
	// reset pin control
	// ********************
	int unsigned since_ff = HOLD_CYC;
	logic        fault_ff = 1'b1;
	logic        pin_ff   = 1'b1;
	assign reset_pin_n = pin_ff;
	// cycles since the fault line fell
	always_ff @(posedge clk) begin
		fault_ff <= fault_n;
		if (fault_ff && !fault_n)
			since_ff <= 0;
		else if (since_ff < HOLD_CYC)
			since_ff <= since_ff + 1;
	end
	// late reset rise
	// rising too early would restart a hot device
	always_ff @(posedge clk) begin
		if (req_reset)
			pin_ff <= 1'b0;
		else if (since_ff >= HOLD_CYC)
			pin_ff <= 1'b1;
	end
endmodule : prot_mcu_model
`default_nettype wire

// [test/prot_chk.sv]
// Purpose: port assertions of the protection block
// Assumes: one clock, rst synchronous active high
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module prot_chk #(
	parameter int FRAME_CYC = 25
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       reset_pin_n,
	input wire logic       heat_warning,
	input wire logic       heat_shutdown,
	input wire logic       supply_low_guard,
	input wire logic [3:0] boot_cap_low,
	input wire logic       fault_n_out,
	input wire logic       fault_n_oe,
	input wire logic       clip_heat_warn_n_out,
	input wire logic       clip_heat_warn_n_oe,
	input wire logic [3:0] hb_hiz,
	input wire logic [3:0] hb_high_off,
	input wire logic [3:0] inject_pulse,
	input wire logic [3:0] pulldown_en,
	input wire logic       ramp_down,
	input wire logic       chk_gnd_test,
	input wire logic       chk_sup_test
);
	// ********************
	// assertions
	// ********************
	localparam int GAP = 4 * FRAME_CYC;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int unsigned gap_ff;
	logic        seen_ff;
	// cycles since last injected pulse, saturating
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_ff  <= 0;
			seen_ff <= 1'b0;
		end else if (inject_pulse[0]) begin
			gap_ff  <= 1;
			seen_ff <= 1'b1;
		end else if (gap_ff < GAP) begin
			gap_ff <= gap_ff + 1;
		end
	end
	a_inject_gap: assert property (
		inject_pulse[0] && seen_ff |-> gap_ff >= GAP) else $error("inject too soon");
	a_clip_width: assert property (
		$rose(clip_heat_warn_n_oe) && !heat_warning && !$past(heat_warning, 4)
		|-> clip_heat_warn_n_oe [*5] ##1 !clip_heat_warn_n_oe) else $error("clip width");
	a_warn_low: assert property (
		heat_warning [*4] |-> clip_heat_warn_n_oe) else $error("warning missing");
	a_heat_latch: assert property (
		(heat_shutdown && reset_pin_n) [*5] ##1 reset_pin_n [*4]
		|-> hb_hiz == 4'hf && fault_n_oe) else $error("heat latch lost");
	a_supply_hiz: assert property (
		(supply_low_guard && reset_pin_n) [*5] |-> hb_hiz == 4'hf && fault_n_oe)
		else $error("supply low ignored");
	a_reset_release: assert property (
		(!reset_pin_n && !chk_gnd_test && !chk_sup_test) [*4] |-> !fault_n_oe)
		else $error("fault not released");
	a_pull_down: assert property (
		(!reset_pin_n && !chk_gnd_test && !chk_sup_test) [*4] |-> pulldown_en == 4'hf)
		else $error("pulldowns off");
	a_ramp_hiz: assert property (
		$fell(ramp_down) && !reset_pin_n |-> ##[0:1] hb_hiz == 4'hf)
		else $error("no hiz after ramp");
	a_check_fault: assert property (
		chk_gnd_test || chk_sup_test |-> ##1 fault_n_oe) else $error("fault high in check");
	a_boot_off: assert property (
		boot_cap_low[3] [*4] |-> hb_high_off[3]) else $error("high side on");
	a_open_drain: assert property (
		fault_n_out == 1'b0 && clip_heat_warn_n_out == 1'b0) else $error("pin level");
endmodule : prot_chk
bind amp_protection_fault_control prot_chk #(.FRAME_CYC(FRAME_CYC)) u_chk (
	.clk, .rst, .reset_pin_n, .heat_warning, .heat_shutdown, .supply_low_guard,
	.boot_cap_low, .fault_n_out, .fault_n_oe, .clip_heat_warn_n_out,
	.clip_heat_warn_n_oe, .hb_hiz, .hb_high_off, .inject_pulse, .pulldown_en,
	.ramp_down, .chk_gnd_test, .chk_sup_test
);
`default_nettype wire

// [test/testbench.sv]
// Purpose: self-checking bench of the protection block
// Assumes: 10 MHz clock, shortened counts
// Notes:   shortened counts keep the run brief
`timescale 1ns/1ps
`default_nettype none
`include "amp_prot_regs.svh"
module testbench;
	// ********************
	// bench
	// ********************
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, reset_pin_n;
	logic        heat_warning, heat_shutdown, supply_low_guard, ext_switch_clock;
	logic        ext_run, req_reset, fault_n_out, fault_n_oe, warn_out, warn_oe;
	logic        ramp_down, gnd_t, sup_t, e, fault_pin, warn_pin, pw;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  boot_cap_low, clip_saturated, short_to_gnd, short_to_supply;
	logic [3:0]  hb_hiz, hb_high_off, inject_pulse;
	logic [1:0]  dc_imbalance;
	logic        por_low;
	logic [3:0]  over_current, pd, hf;
	int          mismatches, n_tests, cyc, i, a, b;
	assign fault_pin = fault_n_oe ? fault_n_out : 1'b1;
	assign warn_pin  = warn_oe ? warn_out : 1'b1;
	amp_protection_fault_control #(.CHK_CYC(4), .RAMP_CYC(4), .OVL_MAX(3)) DUT (
		.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .reset_pin_n, .heat_warning, .heat_shutdown, .supply_low_guard,
		.por_low, .boot_cap_low, .over_current, .clip_saturated,
		.dc_imbalance, .short_to_gnd, .short_to_supply, .ext_switch_clock,
		.fault_n_out, .fault_n_oe, .clip_heat_warn_n_out(warn_out),
		.clip_heat_warn_n_oe(warn_oe), .hb_hiz, .hb_high_off, .hb_flip(hf),
		.inject_pulse, .pulldown_en(pd), .ramp_down, .chk_gnd_test(gnd_t),
		.chk_sup_test(sup_t)
	);
	prot_mcu_model #(.HOLD_CYC(40)) mcu (.clk, .fault_n(fault_pin), .req_reset,
		.reset_pin_n);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// external clock toggles only while running
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ext_run)
			ext_switch_clock <= ~ext_switch_clock;
		if (cyc == 12000) begin
			mismatches++;
			complete_run;
		end
	end
	task automatic complete_run;
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// one apb transfer, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic pin_reset;
		int r = 0;
		req_reset <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			r += ramp_down;
		end
		chk(32'({pd, fault_pin}), 32'h1f); // forced high, pulldowns
		chk(32'(r), 32'h4); // ramp length
		req_reset <= 1'b0;
		for (i = 0; i < 200 && reset_pin_n !== 1'b1; i++)
			@(posedge clk);
		wt(20);
	endtask : pin_reset
	task automatic pins(input logic [4:0] exp);
		chk(32'({hb_hiz, fault_pin}), 32'(exp));
	endtask : pins
	initial begin
		{mismatches, n_tests, cyc} = 0;
		{psel, penable, pwrite, paddr, pwdata, heat_warning, heat_shutdown} <= 0;
		{supply_low_guard, ext_run, ext_switch_clock, req_reset, por_low} <= 0;
		{boot_cap_low, clip_saturated, short_to_supply, dc_imbalance, over_current} <= 0;
		short_to_gnd <= 4'h2;
		rst <= 1'b1;
		wt(10);
		rst <= 1'b0;
		wt(40);
		pins(5'b11110); // held
		chk(32'(sup_t), 32'h0); // order
		short_to_gnd <= 4'h0;
		pw = 1'b0;
		for (i = 0; i < 200 && sup_t !== 1'b1; i++) begin
			pw |= gnd_t;
			@(posedge clk);
		end
		chk(32'({pw, sup_t}), 32'h3); // ground first
		wt(20);
		pins(5'b00001); // released
		short_to_supply <= 4'hf;
		wt(20);
		chk(32'({gnd_t, sup_t, fault_pin}), 32'h1); // no rerun
		short_to_supply <= 4'h0;
		apb(1'b0, `CTRL_OFF, 32'h0);
		chk(q, 32'(`CTRL_RST)); // reset value
		apb(1'b0, 12'h008, 32'h0);
		chk({q[30:0], e}, 32'h1); // unmapped
		// dc imbalance in parallel bridged, single-ended and bridged modes
		for (a = 1; a >= 0; a--) begin
			for (b = 1; b <= 2; b++) begin
				apb(1'b1, `CTRL_OFF, a ? 32'(b) | 32'hffff_fff8 : 32'h0);
				apb(1'b0, `CTRL_OFF, 32'h0);
				chk(q, a ? 32'(b) : 32'h0); // mode
				dc_imbalance <= 2'b01;
				wt(20);
				pins(a ? 5'b00001 : 5'b00110);
				dc_imbalance <= 2'b00;
				wt(10);
				pins(a ? 5'b00001 : 5'b00110); // latched
				if (!a)
					break;
			end
		end
		pin_reset;
		pins(5'b00001); // resumed
		heat_warning <= 1'b1;
		wt(8);
		chk(32'({warn_pin, fault_pin}), 32'h1); // warning
		heat_warning <= 1'b0;
		wt(8);
		chk(32'(warn_pin), 32'h1); // clears
		heat_shutdown <= 1'b1;
		wt(8);
		heat_shutdown <= 1'b0;
		wt(8);
		pins(5'b11110); // latched
		pin_reset;
		pins(5'b00001); // cleared
		supply_low_guard <= 1'b1;
		wt(8);
		pins(5'b11110); // supply low
		supply_low_guard <= 1'b0;
		wt(8);
		pins(5'b00001); // recovered
		boot_cap_low <= 4'h8;
		wt(8);
		chk(32'({hb_high_off, hb_hiz, fault_pin}), 32'h101); // silent
		boot_cap_low <= 4'h0;
		wt(8);
		chk(32'(hb_high_off), 32'h0); // recharged
		clip_saturated <= 4'h1;
		wt(125);
		{a, b} = 0;
		pw = warn_pin;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			a += inject_pulse[0];
			b += (pw && !warn_pin);
			pw = warn_pin;
		end
		chk(32'(a), 32'h2); // every fourth
		chk(32'(b), 32'h8); // clip pulses
		clip_saturated <= 4'h0;
		wt(60);
		chk(32'({inject_pulse, warn_pin}), 32'h1); // self clear
		ext_run <= 1'b1;
		apb(1'b1, `CTRL_OFF, 32'h4);
		wt(20);
		pins(5'b00001); // clock present
		ext_run <= 1'b0;
		wt(60);
		pins(5'b11111); // silent hiz
		ext_run <= 1'b1;
		wt(20);
		pins(5'b00001); // resumes
		over_current <= 4'h1;
		wt(150);
		pins(5'b00110); // overload trip
		// power-on clears the trip while overcurrent goes on, so flips show
		por_low <= 1'b1;
		pw = 1'b0;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			pw |= hf[0];
		end
		pins(5'b11110); // power-on reset global
		chk(32'(pw), 32'h1); // flip under limiting
		{por_low, over_current} <= 0;
		wt(10);
		pins(5'b00001); // trip cleared by power-on
		// second power-up in single-ended mode skips the short check
		por_low <= 1'b1;
		rst     <= 1'b1;
		wt(4);
		rst <= 1'b0;
		apb(1'b1, `CTRL_OFF, 32'h2);
		por_low <= 1'b0;
		pw = 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			pw |= gnd_t | sup_t;
		end
		chk(32'({pw, fault_pin}), 32'h1); // skipped single-ended
		complete_run;
	end
endmodule : testbench
`default_nettype wire
